// [tscm_host_model.sv]
// host processor model on the parallel bus of the switch control block
`timescale 1ns/10ps
module tscm_host_model (
	// clock
	input  wire logic                   clk_sys,
	// answer from the device
	input  wire logic [15:0]            host_rdata_ff,
	input  wire logic                   transfer_ack_n_ff,
	input  wire logic                   transfer_ack_oe_ff,
	// request to the device
	output tscm_pkg::tscm_host_req_type host_req
);
	initial host_req = '{cs_n: 1'b1, ds_n: 1'b1, default: '0};

	// analog loop settles before any access
	task automatic power_up_wait();
		repeat (30000) @(posedge clk_sys);
	endtask : power_up_wait

	// entered just after a rising edge; request held until ack is sampled
	task automatic access(input logic rd, input logic [13:0] addr, input logic [15:0] wdata,
		output logic [15:0] rdata, output int lat, output logic ok);
		int n;
		begin
			ok = 1'b0;
			lat = 0;
			rdata = 16'h0000;
			host_req <= '{cs_n: 1'b0, ds_n: 1'b0, rd: rd, addr: addr, wdata: wdata};
			for (n = 1; n < 40 && !ok; n++)
			begin
				@(posedge clk_sys);
				if (transfer_ack_oe_ff === 1'b1 && transfer_ack_n_ff === 1'b0)
				begin
					ok = 1'b1;
					lat = n;
					rdata = host_rdata_ff;
				end
			end
			// released lines never keep the stale value
			host_req <= '{cs_n: 1'b1, ds_n: 1'b1, rd: ~rd, addr: ~addr, wdata: ~wdata};
			for (n = 0; n < 40 && transfer_ack_oe_ff !== 1'b0; n++)
				@(posedge clk_sys);
			if (transfer_ack_oe_ff !== 1'b0)
				ok = 1'b0;
		end
	endtask : access
endmodule : tscm_host_model

// [tscm_mem.sv]
// one write port, two registered read ports
`timescale 1ns/10ps
module tscm_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8192,
	parameter int AW    = 13
) (
	// clock
	input  wire logic             clk_sys,
	// write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// read ports
	input  wire logic [AW-1:0]    raddr_a,
	output logic      [WIDTH-1:0] rdata_a_ff,
	input  wire logic [AW-1:0]    raddr_b,
	output logic      [WIDTH-1:0] rdata_b_ff
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge clk_sys)
	begin
		if (we)
			store[waddr] <= wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		rdata_a_ff <= store[raddr_a];
		rdata_b_ff <= store[raddr_b];
	end
endmodule : tscm_mem

// [tscm_pkg.sv]
// shared constants and carrier types for the switch control and map block
package tscm_pkg;
	localparam logic [12:0] ADDR_CTRL    = 13'h0000;
	localparam logic [12:0] ADDR_FOR0    = 13'h000A;
	localparam logic [12:0] ADDR_FOR1    = 13'h000B;
	localparam logic [12:0] ADDR_FOR2    = 13'h000C;
	localparam logic [12:0] ADDR_OUTPUT_OFFSET_STREAMS_24_31    = 13'h000D;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [15:0] FOR_RESET    = 16'h0000;
	localparam int          ADDR_SEL_BIT = 13;
	localparam int          STREAM_MSB   = 12;
	localparam int          STREAM_LSB   = 8;
	localparam int          CHAN_MSB     = 7;
	localparam int          N_STREAMS    = 32;
	localparam int          CM_DEPTH     = 8192;
	localparam logic [14:0] PRBS_SEED    = 15'h7FFF;
	// rate codes
	localparam logic [2:0]  RATE_2M      = 3'h0;
	localparam logic [2:0]  RATE_4M      = 3'h1;
	localparam logic [2:0]  RATE_8M      = 3'h2;
	localparam logic [2:0]  RATE_16M     = 3'h3;
	localparam logic [2:0]  RATE_2_4M    = 3'h4;
	localparam logic [2:0]  RATE_4_8M    = 3'h5;
	localparam logic [2:0]  RATE_16_8M   = 3'h6;
	// connection memory modes {hi,lo}
	localparam logic [1:0]  MODE_VAR     = 2'h0;
	localparam logic [1:0]  MODE_MSG     = 2'h1;
	localparam logic [1:0]  MODE_CONST   = 2'h2;
	localparam logic [1:0]  MODE_BER     = 2'h3;

	typedef struct packed {
		logic [2:0] block_prog_data;
		logic       dpll_control;
		logic       clear_error_count;
		logic       begin_error_test;
		logic       begin_frame_eval;
		logic       block_prog_enable;
		logic       memory_block_prog;
		logic       memory_select;
		logic       output_standby;
		logic [2:0] rate_select;
	} tscm_ctrl_type;

	typedef struct packed {
		logic       throughput_mode_hi;
		logic       throughput_mode_lo;
		logic       chan_oe;
		logic [4:0] source_stream_field;
		logic [7:0] source_channel_field;
	} tscm_cm_word_type;

	typedef struct packed {
		logic        cs_n;
		logic        ds_n;
		logic        rd;
		logic [13:0] addr;
		logic [15:0] wdata;
	} tscm_host_req_type;

	typedef struct packed {
		logic       req;
		logic [4:0] stream;
		logic [7:0] channel;
	} tscm_sw_req_type;
endpackage : tscm_pkg

// [tscm_top.sv]
// host map, control register, output advance and connection memory modes
// What this block does
// - two-bit code advances stream bit zero
// - advance only in 8,16, 4/8 and 16/8 rates
// - address bit 13 low selects registers
// - bit 13 high selects memory by select
// - data memory by input, connection by output
// - data memory valid on second read
// - control register holds listed fields
// - connection word mode bits pick behaviour
// - delay modes use source stream and channel
// - message mode sends low eight bits
// - error test mode sends random pattern
// - acknowledge low at completion, released after
// - outputs high impedance while drive enable and the output standby bit are both low
`timescale 1ns/10ps
module tscm_top (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        nrst,
	// host parallel bus
	input  wire tscm_pkg::tscm_host_req_type host_req,
	output logic      [15:0]                 host_rdata_ff,
	output logic                             host_data_oe_ff,
	output logic                             transfer_ack_n_ff,
	output logic                             transfer_ack_oe_ff,
	// serial timing and input data
	input  wire logic                        frame_pulse_in,
	input  wire logic                        output_drive_enable,
	input  wire logic                        in_we,
	input  wire logic [12:0]                 in_addr,
	input  wire logic [7:0]                  in_byte,
	// output channel lookup
	input  wire tscm_pkg::tscm_sw_req_type   sw_req,
	output logic                             sw_valid_ff,
	output logic      [7:0]                  sw_byte_ff,
	output logic                             sw_drive_ff,
	output logic                             sw_const_delay_ff,
	// stream controls
	output logic      [63:0]                 stream_advance_sel_ff,
	output logic                             serial_out_hiz_ff,
	output tscm_pkg::tscm_ctrl_type          ctrl_ff
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_ACK  = 2'b10
	} tscm_bus_state_type;

	tscm_bus_state_type        state_ff;
	logic [3:0][15:0]          for_ff;
	logic [12:0]               addr_ff;
	logic                      is_dm_ff;
	logic [15:0]               cm_rd_a;
	logic [15:0]               cm_rd_b;
	logic [7:0]                dm_rd_a;
	logic [7:0]                dm_rd_b;
	logic [7:0]                dm_hold_ff;
	logic                      sweep_ff;
	logic [12:0]               sweep_addr_ff;
	logic [14:0]               prbs_ff;
	logic                      s1_valid_ff;
	logic                      s2_valid_ff;
	tscm_pkg::tscm_cm_word_type s2_word_ff;
	logic                      take;
	logic                      sel_mem;
	logic                      cm_we;
	logic [12:0]               cm_waddr;
	logic [15:0]               cm_wdata;
	logic [15:0]               reg_rdata;

	function automatic logic advance_allowed(input logic [2:0] rate);
		advance_allowed = (rate == tscm_pkg::RATE_8M) || (rate == tscm_pkg::RATE_16M) ||
			(rate == tscm_pkg::RATE_4_8M) || (rate == tscm_pkg::RATE_16_8M);
	endfunction : advance_allowed

	// refused while a block sweep owns the connection memory write port
	assign take    = (state_ff == ST_IDLE) && !host_req.cs_n && !host_req.ds_n && !sweep_ff;
	assign sel_mem = host_req.addr[tscm_pkg::ADDR_SEL_BIT];

	always_comb
	begin
		unique case (host_req.addr[12:0])
			tscm_pkg::ADDR_CTRL: reg_rdata = {2'b00, ctrl_ff};
			tscm_pkg::ADDR_FOR0: reg_rdata = for_ff[0];
			tscm_pkg::ADDR_FOR1: reg_rdata = for_ff[1];
			tscm_pkg::ADDR_FOR2: reg_rdata = for_ff[2];
			tscm_pkg::ADDR_OUTPUT_OFFSET_STREAMS_24_31: reg_rdata = for_ff[3];
			default:             reg_rdata = 16'h0000;
		endcase
	end

	// register writes; block-program bit self-clears at sweep end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_ff <= tscm_pkg::tscm_ctrl_type'(tscm_pkg::CTRL_RESET[13:0]);
			for_ff  <= {4{tscm_pkg::FOR_RESET}};
		end
		else if (take && !sel_mem && !host_req.rd)
		begin
			unique case (host_req.addr[12:0])
				// upper two bits of the control word are unused
				tscm_pkg::ADDR_CTRL: ctrl_ff   <= tscm_pkg::tscm_ctrl_type'(host_req.wdata[13:0]);
				tscm_pkg::ADDR_FOR0: for_ff[0] <= host_req.wdata;
				tscm_pkg::ADDR_FOR1: for_ff[1] <= host_req.wdata;
				tscm_pkg::ADDR_FOR2: for_ff[2] <= host_req.wdata;
				tscm_pkg::ADDR_OUTPUT_OFFSET_STREAMS_24_31: for_ff[3] <= host_req.wdata;
				default:             ;
			endcase
		end
		else if (sweep_ff && (sweep_addr_ff == 13'h1FFF))
			ctrl_ff.memory_block_prog <= 1'b0;
	end

	// block programming sweep over every connection word
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			sweep_ff      <= 1'b0;
			sweep_addr_ff <= 13'h0000;
		end
		else if (sweep_ff)
		begin
			sweep_addr_ff <= sweep_addr_ff + 13'h0001;
			sweep_ff      <= (sweep_addr_ff != 13'h1FFF);
		end
		else if (ctrl_ff.memory_block_prog && ctrl_ff.block_prog_enable)
		begin
			sweep_ff      <= 1'b1;
			sweep_addr_ff <= 13'h0000;
		end
	end

	always_comb
	begin
		cm_we    = 1'b0;
		cm_waddr = host_req.addr[12:0];
		cm_wdata = host_req.wdata;
		if (sweep_ff)
		begin
			cm_we    = 1'b1;
			cm_waddr = sweep_addr_ff;
			cm_wdata = {ctrl_ff.block_prog_data, 13'h0000};
		end
		else if (take && sel_mem && ctrl_ff.memory_select && !host_req.rd)
			cm_we = 1'b1;
	end

	// connection memory: stream = output stream, channel = output channel
	tscm_mem #(.WIDTH(16), .DEPTH(tscm_pkg::CM_DEPTH), .AW(13)) u_cm (
		.clk_sys    (clk_sys),
		.we         (cm_we),
		.waddr      (cm_waddr),
		.wdata      (cm_wdata),
		.raddr_a    (host_req.addr[12:0]),
		.rdata_a_ff (cm_rd_a),
		.raddr_b    ({sw_req.stream, sw_req.channel}),
		.rdata_b_ff (cm_rd_b)
	);

	// data memory: stream = input stream, channel = input channel
	tscm_mem #(.WIDTH(8), .DEPTH(tscm_pkg::CM_DEPTH), .AW(13)) u_dm (
		.clk_sys    (clk_sys),
		.we         (in_we),
		.waddr      (in_addr),
		.wdata      (in_byte),
		.raddr_a    (host_req.addr[12:0]),
		.rdata_a_ff (dm_rd_a),
		.raddr_b    ({cm_rd_b[12:8], cm_rd_b[7:0]}),
		.rdata_b_ff (dm_rd_b)
	);

	// host bus sequencing and acknowledge
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff           <= ST_IDLE;
			addr_ff            <= 13'h0000;
			is_dm_ff           <= 1'b0;
			host_rdata_ff      <= 16'h0000;
			host_data_oe_ff    <= 1'b0;
			transfer_ack_n_ff  <= 1'b1;
			transfer_ack_oe_ff <= 1'b0;
			dm_hold_ff         <= 8'h00;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					if (take && sel_mem)
					begin
						state_ff <= ST_WAIT;
						addr_ff  <= host_req.addr[12:0];
						is_dm_ff <= !ctrl_ff.memory_select;
					end
					else if (take)
					begin
						state_ff           <= ST_ACK;
						host_rdata_ff      <= reg_rdata;
						host_data_oe_ff    <= host_req.rd;
						transfer_ack_n_ff  <= 1'b0;
						transfer_ack_oe_ff <= 1'b1;
					end
				end
				ST_WAIT:
				begin
					state_ff           <= ST_ACK;
					host_data_oe_ff    <= host_req.rd;
					transfer_ack_n_ff  <= 1'b0;
					transfer_ack_oe_ff <= 1'b1;
					if (is_dm_ff)
					begin
						// staged through a hold: only a repeated read is current
						host_rdata_ff <= {8'h00, dm_hold_ff};
						dm_hold_ff    <= dm_rd_a;
					end
					else
						host_rdata_ff <= cm_rd_a;
				end
				ST_ACK:
				begin
					if (host_req.cs_n || host_req.ds_n)
					begin
						state_ff           <= ST_IDLE;
						host_data_oe_ff    <= 1'b0;
						transfer_ack_n_ff  <= 1'b1;
						transfer_ack_oe_ff <= 1'b0;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// per-stream advance, latched on the frame pulse
	generate
		for (genvar s = 0; s < tscm_pkg::N_STREAMS; s++)
		begin : g_adv
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
					stream_advance_sel_ff[2*s +: 2] <= 2'h0;
				else if (frame_pulse_in)
					stream_advance_sel_ff[2*s +: 2] <= advance_allowed(ctrl_ff.rate_select) ?
						for_ff[s/8][2*(s%8) +: 2] : 2'h0;
			end
		end
	endgenerate

	// serial outputs floated until drive enable or standby release
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			serial_out_hiz_ff <= 1'b1;
		else
			serial_out_hiz_ff <= !(output_drive_enable || ctrl_ff.output_standby);
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			prbs_ff <= tscm_pkg::PRBS_SEED;
		else
			prbs_ff <= {prbs_ff[13:0], prbs_ff[14] ^ prbs_ff[13]};
	end

	// output channel pipeline: word fetch, source fetch, mode select
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_valid_ff       <= 1'b0;
			s2_valid_ff       <= 1'b0;
			s2_word_ff        <= '0;
			sw_valid_ff       <= 1'b0;
			sw_byte_ff        <= 8'h00;
			sw_drive_ff       <= 1'b0;
			sw_const_delay_ff <= 1'b0;
		end
		else
		begin
			s1_valid_ff <= sw_req.req;
			s2_valid_ff <= s1_valid_ff;
			s2_word_ff  <= cm_rd_b;
			sw_valid_ff <= s2_valid_ff;
			sw_drive_ff <= s2_valid_ff && s2_word_ff.chan_oe && !serial_out_hiz_ff;
			unique case ({s2_word_ff.throughput_mode_hi, s2_word_ff.throughput_mode_lo})
				tscm_pkg::MODE_VAR:   sw_byte_ff <= dm_rd_b;
				tscm_pkg::MODE_CONST: sw_byte_ff <= dm_rd_b;
				tscm_pkg::MODE_MSG:   sw_byte_ff <= s2_word_ff.source_channel_field;
				tscm_pkg::MODE_BER:   sw_byte_ff <= prbs_ff[7:0];
			endcase
			sw_const_delay_ff <= s2_word_ff.throughput_mode_hi && !s2_word_ff.throughput_mode_lo;
		end
	end

	a_hiz_follows_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
		!output_drive_enable && !ctrl_ff.output_standby |=> serial_out_hiz_ff)
		else $error("serial outputs not floated");
	a_adv_low_rate: assert property (@(posedge clk_sys) disable iff (!nrst)
		frame_pulse_in && !advance_allowed(ctrl_ff.rate_select) |=> stream_advance_sel_ff == 64'h0)
		else $error("advance applied in low rate");
	a_adv_takes_code: assert property (@(posedge clk_sys) disable iff (!nrst)
		frame_pulse_in && advance_allowed(ctrl_ff.rate_select) |=> stream_advance_sel_ff == $past(for_ff))
		else $error("advance code not taken");
	a_adv_frame_only: assert property (@(posedge clk_sys) disable iff (!nrst)
		!frame_pulse_in |=> $stable(stream_advance_sel_ff))
		else $error("advance changed off frame");
	a_reg_ack_timing: assert property (@(posedge clk_sys) disable iff (!nrst)
		take && !sel_mem |=> !transfer_ack_n_ff && transfer_ack_oe_ff)
		else $error("register ack late");
	a_ack_release: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_ff == ST_ACK && (host_req.cs_n || host_req.ds_n) |=> !transfer_ack_oe_ff && transfer_ack_n_ff)
		else $error("ack not released");
	a_mem_ack_timing: assert property (@(posedge clk_sys) disable iff (!nrst)
		take && sel_mem |=> transfer_ack_oe_ff == 1'b0 ##1 !transfer_ack_n_ff)
		else $error("memory ack timing wrong");
	a_dm_second_read: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_ff == ST_WAIT && is_dm_ff |=> host_rdata_ff == {8'h00, $past(dm_hold_ff)})
		else $error("data memory read not staged");
	a_msg_byte: assert property (@(posedge clk_sys) disable iff (!nrst)
		s2_valid_ff && s2_word_ff.throughput_mode_lo && !s2_word_ff.throughput_mode_hi
		|=> sw_byte_ff == $past(s2_word_ff.source_channel_field))
		else $error("message byte wrong");
	a_switched_byte: assert property (@(posedge clk_sys) disable iff (!nrst)
		s2_valid_ff && !s2_word_ff.throughput_mode_lo |=> sw_byte_ff == $past(dm_rd_b))
		else $error("switched byte wrong");
	a_ber_byte: assert property (@(posedge clk_sys) disable iff (!nrst)
		s2_valid_ff && s2_word_ff.throughput_mode_lo && s2_word_ff.throughput_mode_hi
		|=> sw_byte_ff == $past(prbs_ff[7:0]))
		else $error("test pattern byte wrong");
endmodule : tscm_top

// [tscm_top_tb.sv]
// self-checking bench for the switch control and map block
`timescale 1ns/10ps
module tscm_top_tb;
	logic                        clk_sys, nrst, frame_pulse_in, output_drive_enable, in_we;
	logic [12:0]                 in_addr;
	logic [7:0]                  in_byte, b1;
	tscm_pkg::tscm_host_req_type host_req;
	tscm_pkg::tscm_sw_req_type   sw_req;
	logic [15:0]                 host_rdata_ff, q;
	logic                        host_data_oe_ff, transfer_ack_n_ff, transfer_ack_oe_ff;
	logic                        sw_valid_ff, sw_drive_ff, sw_const_delay_ff, serial_out_hiz_ff;
	logic [7:0]                  sw_byte_ff;
	logic [63:0]                 stream_advance_sel_ff;
	tscm_pkg::tscm_ctrl_type     ctrl_ff;
	int                          fails = 0;
	int                          total_checks = 0;
	logic [15:0]                 fr [4] = '{16'hE41B, 16'h1BE4, 16'h936C, 16'h6C93};
	// var, const, message with channel off, message, error test
	logic [15:0]                 cw [5] = '{16'h2305, 16'hA305, 16'h5F3C, 16'h7F3C, 16'hE305};
	logic [7:0]                  eb [5] = '{8'hA5, 8'hA5, 8'h3C, 8'h3C, 8'h00};
	logic                        ec [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic                        ed [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

	always #10 clk_sys = ~clk_sys;

	tscm_host_model HOST (.clk_sys(clk_sys), .host_rdata_ff(host_rdata_ff), .transfer_ack_n_ff(transfer_ack_n_ff),
		.transfer_ack_oe_ff(transfer_ack_oe_ff), .host_req(host_req));

	tscm_top DUT (.clk_sys(clk_sys), .nrst(nrst), .host_req(host_req), .host_rdata_ff(host_rdata_ff),
		.host_data_oe_ff(host_data_oe_ff), .transfer_ack_n_ff(transfer_ack_n_ff),
		.transfer_ack_oe_ff(transfer_ack_oe_ff), .frame_pulse_in(frame_pulse_in),
		.output_drive_enable(output_drive_enable), .in_we(in_we), .in_addr(in_addr), .in_byte(in_byte),
		.sw_req(sw_req), .sw_valid_ff(sw_valid_ff), .sw_byte_ff(sw_byte_ff), .sw_drive_ff(sw_drive_ff),
		.sw_const_delay_ff(sw_const_delay_ff), .stream_advance_sel_ff(stream_advance_sel_ff),
		.serial_out_hiz_ff(serial_out_hiz_ff), .ctrl_ff(ctrl_ff));

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// registers answer one edge sooner than the memories
	task automatic bus(input logic rd, input logic [13:0] a, input logic [15:0] wd);
		int   lat;
		logic ok;
		begin
			HOST.access(rd, a, wd, q, lat, ok);
			if (ok !== 1'b1)
			begin
				fails++;
				summarize();
			end
			check(64'(lat), a[13] ? 64'd3 : 64'd2);
		end
	endtask : bus

	task automatic lookup(input logic [4:0] s, input logic [7:0] c);
		int n;
		begin
			sw_req <= '{req: 1'b1, stream: s, channel: c};
			@(posedge clk_sys);
			sw_req <= '{req: 1'b0, stream: ~s, channel: ~c};
			for (n = 0; n < 8 && sw_valid_ff !== 1'b1; n++)
				@(posedge clk_sys);
			if (sw_valid_ff !== 1'b1)
			begin
				fails++;
				summarize();
			end
		end
	endtask : lookup

	initial
	begin
		clk_sys = 1'b0;
		nrst = 1'b0;
		frame_pulse_in = 1'b0;
		output_drive_enable = 1'b0;
		in_we = 1'b0;
		in_addr = 13'h0000;
		in_byte = 8'h00;
		sw_req = '0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		HOST.power_up_wait();
		check(serial_out_hiz_ff, 1);
		bus(1, 14'h0000, 16'h0000);
		check(q, tscm_pkg::CTRL_RESET);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, {1'b0, tscm_pkg::ADDR_FOR0 + 13'(i)}, 16'h0000);
			check(q, tscm_pkg::FOR_RESET);
		end
		bus(1, 14'h1FFF, 16'h0000);
		check(q, 16'h0000);
		bus(0, 14'h0000, 16'h3C1A);
		bus(1, 14'h0000, 16'h0000);
		check(q, 16'h3C1A);
		check(ctrl_ff, 16'h3C1A);
		repeat (2) @(posedge clk_sys);
		check(serial_out_hiz_ff, 0);
		for (int i = 0; i < 4; i++)
			bus(0, {1'b0, tscm_pkg::ADDR_FOR0 + 13'(i)}, fr[i]);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, {1'b0, tscm_pkg::ADDR_FOR0 + 13'(i)}, 16'h0000);
			check(q, fr[i]);
		end
		check(stream_advance_sel_ff, 0);
		// every rate: advance only where the rate allows it
		for (int r = 0; r < 7; r++)
		begin
			bus(0, 14'h0000, 16'h3C18 | 16'(r));
			frame_pulse_in <= 1'b1;
			@(posedge clk_sys);
			frame_pulse_in <= 1'b0;
			repeat (2) @(posedge clk_sys);
			check(stream_advance_sel_ff, (r == 0 || r == 1 || r == 4) ? 64'h0 : {fr[3], fr[2], fr[1], fr[0]});
		end
		bus(0, 14'h0000, 16'h3C1A);
		in_we <= 1'b1;
		in_addr <= {5'd3, 8'd5};
		in_byte <= 8'hA5;
		@(posedge clk_sys);
		in_we <= 1'b0;
		@(posedge clk_sys);
		for (int k = 0; k < 5; k++)
		begin
			bus(0, {1'b1, 5'd2, 8'd7}, cw[k]);
			bus(1, {1'b1, 5'd2, 8'd7}, 16'h0000);
			check(q, cw[k]);
			lookup(5'd2, 8'd7);
			b1 = sw_byte_ff;
			if (k != 4)
				check(sw_byte_ff, eb[k]);
			check(sw_const_delay_ff, ec[k]);
			check(sw_drive_ff, ed[k]);
			if (k == 4)
			begin
				lookup(5'd2, 8'd7);
				check(sw_byte_ff !== b1, 1);
			end
		end
		bus(0, 14'h0000, 16'h3C12);
		repeat (2) @(posedge clk_sys);
		check(serial_out_hiz_ff, 1);
		lookup(5'd2, 8'd7);
		check(sw_drive_ff, 0);
		output_drive_enable <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check(serial_out_hiz_ff, 0);
		bus(0, 14'h0000, 16'h3C0A);
		// first data memory read is stale by design
		bus(1, {1'b1, 5'd3, 8'd5}, 16'h0000);
		bus(1, {1'b1, 5'd3, 8'd5}, 16'h0000);
		check(q[7:0], 8'hA5);
		bus(0, 14'h0000, 16'h2872);
		repeat (8192) @(posedge clk_sys);
		for (int n = 0; n < 100 && ctrl_ff.memory_block_prog !== 1'b0; n++)
			@(posedge clk_sys);
		check(ctrl_ff.memory_block_prog, 0);
		bus(1, {1'b1, 5'd9, 8'd200}, 16'h0000);
		check(q, 16'hA000);
		lookup(5'd9, 8'd200);
		check(sw_const_delay_ff, 1);
		check(sw_drive_ff, 1);
		summarize();
	end
endmodule : tscm_top_tb
